/* rtl/iwc_pkg.sv */
// Shared constants and types for the interrupt and wake control register.
package iwc_pkg;
    // Fixed register address carried in bits 15:13 of each serial frame.
    localparam logic [2:0] IWC_REG_ADDR = 3'h2;
    localparam int IWC_FRAME_BITS = 16;
    // Field positions inside the 16-bit word.
    localparam int IWC_ADDR_MSB = 15;
    localparam int IWC_ADDR_LSB = 13;
    localparam int IWC_LOCK_POS = 12;
    localparam int IWC_MAIN_UV_POS = 11;
    localparam int IWC_CAN_UV_POS = 10;
    localparam int IWC_WA_EDGE_LSB = 6;
    localparam int IWC_WB_EDGE_LSB = 4;
    localparam int IWC_LOWPWR_POS = 3;
    localparam int IWC_TRIP_POS = 2;
    localparam int IWC_WA_SYNC_POS = 1;
    localparam int IWC_WB_SYNC_POS = 0;
    // Reserved bits 9:8 always read as zero.
    localparam logic [1:0] IWC_RSVD_VAL = 2'h0;
    // Sampling intervals and core clock rate.
    localparam int IWC_CLK_HZ = 40000000;
    localparam int IWC_SHORT_MS = 16;
    localparam int IWC_LONG_MS = 64;
    localparam int IWC_SHORT_CYC = IWC_SHORT_MS * (IWC_CLK_HZ / 1000);
    localparam int IWC_LONG_CYC = IWC_LONG_MS * (IWC_CLK_HZ / 1000);
    // Width of the bias pulse that precedes a synchronized sample.
    localparam int IWC_BIAS_CYC = 40;
    // Mode field: leading 1 means a normal mode.
    localparam int IWC_MODE_NORMAL_BIT = 1;
    // Wake edge selection codes.
    typedef enum logic [1:0] {
        IWC_EDGE_OFF = 2'b00,
        IWC_EDGE_RISE = 2'b01,
        IWC_EDGE_FALL = 2'b10,
        IWC_EDGE_BOTH = 2'b11
    } iwc_edge_t;
    // Writable register content; all zero at power-on.
    typedef struct packed {
        logic write_lock;
        logic main_supply_uv_irq_en;
        logic can_supply_uv_irq_en;
        logic [1:0] wake_in_a_irq_edge;
        logic [1:0] wake_in_b_irq_edge;
        logic transceiver_lowpower_sel;
        logic reset_trip_level_sel;
        logic wake_in_a_sync_sample;
        logic wake_in_b_sync_sample;
    } iwc_reg_t;
    localparam iwc_reg_t IWC_REG_RESET = '0;
    // Transceiver control outputs.
    typedef struct packed {
        logic active;
        logic lowpower;
        logic bus_wake_det_en;
        logic can_wake_irq_en;
        logic rx_wake_clr;
    } iwc_xcvr_t;
endpackage

/* rtl/iwc_ctrl.sv */
// Interrupt and wake control register with its serial access and outputs.
`timescale 1ns/100ps
module iwc_ctrl
    import iwc_pkg::*;
#(
    parameter int SHORT_CYC = IWC_SHORT_CYC,
    parameter int LONG_CYC = IWC_LONG_CYC,
    parameter int BIAS_CYC = IWC_BIAS_CYC
) (
    input wire logic I_CORE_CLK, // Core clock, 40 MHz.
    input wire logic I_RST_N, // Asynchronous reset, active low.
    input wire logic I_SPI_SCK, // Serial clock pin.
    input wire logic I_SPI_SDI, // Serial data in pin.
    input wire logic I_SPI_CS_N, // Serial chip select pin, active low.
    output logic O_SPI_SDO, // Serial data out.
    output logic O_SPI_SDO_OE, // Data out enable, high while driven.
    input wire logic [1:0] I_CHIP_MODE_FIELD, // Chip operating mode.
    input wire logic I_MAIN_SUPPLY_UV_WARN, // Main supply warning event.
    input wire logic I_TRANSCEIVER_SUPPLY_UV_WARN, // Transceiver supply event.
    input wire logic I_WAKE_IN_A, // Wake input A pin.
    input wire logic I_WAKE_IN_B, // Wake input B pin.
    input wire logic I_WAKE_BIAS_RATE_SEL, // Bias rate: 0 short, 1 long.
    output logic O_MAIN_SUPPLY_UV_IRQ, // Main supply interrupt request.
    output logic O_CAN_SUPPLY_UV_IRQ, // Transceiver supply interrupt request.
    output logic O_WAKE_IN_A_IRQ, // Wake A interrupt request.
    output logic O_WAKE_IN_B_IRQ, // Wake B interrupt request.
    output logic O_WAKE_BIAS_OUT, // Wake bias pulse.
    output logic O_XCVR_ACTIVE, // Transceiver active.
    output logic O_XCVR_LOWPOWER, // Transceiver low-power.
    output logic O_BUS_WAKE_DET_EN, // Bus wake detection enabled.
    output logic O_CAN_WAKE_IRQ_EN, // CAN wake interrupts allowed.
    output logic O_TRANSCEIVER_RX_WAKE_CLR, // Wake flag on receive out cleared.
    output logic O_RESET_TRIP_LEVEL_SEL // Reset trip level: 0 90 %, 1 70 %.
);
    localparam int CW = $clog2(LONG_CYC + 1);
    localparam logic [CW-1:0] SHORT_LAST = CW'(SHORT_CYC - 1);
    localparam logic [CW-1:0] LONG_LAST = CW'(LONG_CYC - 1);
    localparam logic [CW-1:0] BIAS_W = CW'(BIAS_CYC);

    // Refuse sample periods that leave no room for the bias pulse.
    initial begin
        if (BIAS_CYC < 1 || SHORT_CYC <= BIAS_CYC || LONG_CYC < SHORT_CYC) begin
            $error("iwc_ctrl: bad sample period parameters");
        end
    end

    // Pin synchronisers: three stages, filtered level moves when 2 and 3 agree.
    logic [4:0] pin_raw;
    logic [4:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
    assign pin_raw = {I_WAKE_IN_B, I_WAKE_IN_A, I_SPI_SDI, I_SPI_SCK,
                      I_SPI_CS_N};
    always_comb begin
        filt_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & filt_r);
    end
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s1_r <= 5'h1f;
            s2_r <= 5'h1f;
            s3_r <= 5'h1f;
            filt_r <= 5'h1f;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    // Serial frame handling and the register itself.
    logic cs_n_d_r, sck_d_r;
    logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic [4:0] bits_r, bits_nxt;
    logic sdo_oe_r, sdo_oe_nxt;
    iwc_reg_t reg_r, reg_nxt;
    logic [15:0] rd_word;
    logic sck_rise, sck_fall, cs_fall, cs_rise, frame_ok;
    always_comb begin
        rd_word = {IWC_REG_ADDR, reg_r.write_lock,
                   reg_r.main_supply_uv_irq_en, reg_r.can_supply_uv_irq_en,
                   IWC_RSVD_VAL, reg_r.wake_in_a_irq_edge,
                   reg_r.wake_in_b_irq_edge, reg_r.transceiver_lowpower_sel,
                   reg_r.reset_trip_level_sel, reg_r.wake_in_a_sync_sample,
                   reg_r.wake_in_b_sync_sample};
    end
    assign sck_rise = filt_r[1] & ~sck_d_r & ~filt_r[0];
    assign sck_fall = ~filt_r[1] & sck_d_r & ~filt_r[0];
    assign cs_fall = ~filt_r[0] & cs_n_d_r;
    assign cs_rise = filt_r[0] & ~cs_n_d_r;
    assign frame_ok = (bits_r == 5'(IWC_FRAME_BITS))
                      && (rx_r[IWC_ADDR_MSB:IWC_ADDR_LSB] == IWC_REG_ADDR);
    always_comb begin
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        bits_nxt = bits_r;
        sdo_oe_nxt = sdo_oe_r;
        reg_nxt = reg_r;
        if (cs_fall) begin
            tx_nxt = rd_word;
            bits_nxt = 5'h0;
            sdo_oe_nxt = 1'b1;
        end
        if (sck_rise) begin
            rx_nxt = {rx_r[14:0], filt_r[2]};
            if (bits_r != 5'h1f) begin
                bits_nxt = bits_r + 5'h1;
            end
        end
        if (sck_fall) begin
            tx_nxt = {tx_r[14:0], 1'b0};
        end
        if (cs_rise) begin
            sdo_oe_nxt = 1'b0;
            if (frame_ok && !reg_r.write_lock) begin
                reg_nxt.write_lock = rx_r[IWC_LOCK_POS];
                reg_nxt.main_supply_uv_irq_en = rx_r[IWC_MAIN_UV_POS];
                reg_nxt.can_supply_uv_irq_en = rx_r[IWC_CAN_UV_POS];
                reg_nxt.wake_in_a_irq_edge =
                    rx_r[IWC_WA_EDGE_LSB +: 2];
                reg_nxt.wake_in_b_irq_edge =
                    rx_r[IWC_WB_EDGE_LSB +: 2];
                reg_nxt.transceiver_lowpower_sel = rx_r[IWC_LOWPWR_POS];
                reg_nxt.reset_trip_level_sel = rx_r[IWC_TRIP_POS];
                reg_nxt.wake_in_a_sync_sample = rx_r[IWC_WA_SYNC_POS];
                reg_nxt.wake_in_b_sync_sample = rx_r[IWC_WB_SYNC_POS];
            end
        end
    end
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cs_n_d_r <= 1'b1;
            sck_d_r <= 1'b1;
            rx_r <= 16'h0;
            tx_r <= 16'h0;
            bits_r <= 5'h0;
            sdo_oe_r <= 1'b0;
            reg_r <= IWC_REG_RESET;
        end else begin
            cs_n_d_r <= filt_r[0];
            sck_d_r <= filt_r[1];
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            bits_r <= bits_nxt;
            sdo_oe_r <= sdo_oe_nxt;
            reg_r <= reg_nxt;
        end
    end
    assign O_SPI_SDO = tx_r[15];
    assign O_SPI_SDO_OE = sdo_oe_r;

    // Sample divider: bias pulse at the end of each period, then one tick.
    logic [CW-1:0] cnt_r, cnt_nxt, last;
    logic any_sync, tick_r, tick_nxt, bias_r, bias_nxt;
    assign any_sync = reg_r.wake_in_a_sync_sample
                      | reg_r.wake_in_b_sync_sample;
    assign last = I_WAKE_BIAS_RATE_SEL ? LONG_LAST : SHORT_LAST;
    always_comb begin
        cnt_nxt = (cnt_r >= last) ? '0 : cnt_r + CW'(1);
        tick_nxt = any_sync && (cnt_r == last);
        bias_nxt = any_sync && (cnt_nxt > last - BIAS_W);
    end
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
            bias_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
            bias_r <= bias_nxt;
        end
    end
    assign O_WAKE_BIAS_OUT = bias_r;

    // Per wake input: sampled level and edge-selected interrupt request.
    logic [1:0] sync_sel, smp_r, wirq_r;
    logic [1:0][1:0] edge_sel;
    assign sync_sel = {reg_r.wake_in_b_sync_sample,
                       reg_r.wake_in_a_sync_sample};
    assign edge_sel = {reg_r.wake_in_b_irq_edge, reg_r.wake_in_a_irq_edge};
    for (genvar g = 0; g < 2; g++) begin : g_wake
        logic smp_nxt, irq_nxt, rise, fall;
        always_comb begin
            smp_nxt = (!sync_sel[g] || tick_r) ? filt_r[3 + g]
                                               : smp_r[g];
            rise = smp_nxt & ~smp_r[g];
            fall = ~smp_nxt & smp_r[g];
            irq_nxt = (edge_sel[g][0] & rise) | (edge_sel[g][1] & fall);
        end
        always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
            if (!I_RST_N) begin
                smp_r[g] <= 1'b1;
                wirq_r[g] <= 1'b0;
            end else begin
                smp_r[g] <= smp_nxt;
                wirq_r[g] <= irq_nxt;
            end
        end
    end
    assign O_WAKE_IN_A_IRQ = wirq_r[0];
    assign O_WAKE_IN_B_IRQ = wirq_r[1];

    // Supply interrupts, transceiver mode and trip level outputs.
    iwc_xcvr_t xc_r, xc_nxt;
    logic main_irq_r, can_irq_r, trip_r;
    logic normal;
    assign normal = I_CHIP_MODE_FIELD[IWC_MODE_NORMAL_BIT];
    always_comb begin
        xc_nxt = '0;
        if (reg_r.transceiver_lowpower_sel) begin
            xc_nxt.lowpower = 1'b1;
            xc_nxt.bus_wake_det_en = 1'b1;
            xc_nxt.can_wake_irq_en = 1'b1;
        end else if (normal) begin
            xc_nxt.active = 1'b1;
            xc_nxt.rx_wake_clr = 1'b1;
        end
    end
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            xc_r <= '0;
            main_irq_r <= 1'b0;
            can_irq_r <= 1'b0;
            trip_r <= 1'b0;
        end else begin
            xc_r <= xc_nxt;
            main_irq_r <= I_MAIN_SUPPLY_UV_WARN
                          & reg_r.main_supply_uv_irq_en;
            can_irq_r <= I_TRANSCEIVER_SUPPLY_UV_WARN
                         & reg_r.can_supply_uv_irq_en;
            trip_r <= reg_r.reset_trip_level_sel;
        end
    end
    assign O_MAIN_SUPPLY_UV_IRQ = main_irq_r;
    assign O_CAN_SUPPLY_UV_IRQ = can_irq_r;
    assign O_XCVR_ACTIVE = xc_r.active;
    assign O_XCVR_LOWPOWER = xc_r.lowpower;
    assign O_BUS_WAKE_DET_EN = xc_r.bus_wake_det_en;
    assign O_CAN_WAKE_IRQ_EN = xc_r.can_wake_irq_en;
    assign O_TRANSCEIVER_RX_WAKE_CLR = xc_r.rx_wake_clr;
    assign O_RESET_TRIP_LEVEL_SEL = trip_r;

    // Checks on register, interrupt and transceiver behaviour.
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    lock_hold_a: assert property (reg_r.write_lock |=> reg_r == $past(reg_r))
        else $error("locked register changed");
    main_uv_gate_a: assert property (O_MAIN_SUPPLY_UV_IRQ |->
        $past(reg_r.main_supply_uv_irq_en) && $past(I_MAIN_SUPPLY_UV_WARN))
        else $error("main supply interrupt while disabled");
    can_uv_gate_a: assert property (O_CAN_SUPPLY_UV_IRQ |->
        $past(reg_r.can_supply_uv_irq_en)) else $error("can uv irq disabled");
    wake_a_edge_a: assert property (O_WAKE_IN_A_IRQ |->
        $past(reg_r.wake_in_a_irq_edge) != IWC_EDGE_OFF)
        else $error("wake A interrupt while off");
    wake_b_edge_a: assert property (O_WAKE_IN_B_IRQ |->
        $past(reg_r.wake_in_b_irq_edge) != IWC_EDGE_OFF)
        else $error("wake B interrupt while off");
    xcvr_normal_a: assert property (normal && !reg_r.transceiver_lowpower_sel
        |=> O_XCVR_ACTIVE && O_TRANSCEIVER_RX_WAKE_CLR && !O_XCVR_LOWPOWER)
        else $error("transceiver not active in normal mode");
    xcvr_off_a: assert property (!normal && !reg_r.transceiver_lowpower_sel
        |=> !O_XCVR_ACTIVE && !O_BUS_WAKE_DET_EN && !O_CAN_WAKE_IRQ_EN)
        else $error("transceiver not off in standby");
    xcvr_lowpwr_a: assert property (reg_r.transceiver_lowpower_sel
        |=> O_XCVR_LOWPOWER && O_BUS_WAKE_DET_EN && O_CAN_WAKE_IRQ_EN)
        else $error("transceiver not low-power");
    trip_level_a: assert property (##1 O_RESET_TRIP_LEVEL_SEL ==
        $past(reg_r.reset_trip_level_sel)) else $error("trip level wrong");
    sync_hold_a: assert property (reg_r.wake_in_a_sync_sample && !tick_r
        |=> $stable(smp_r[0])) else $error("wake A sampled off tick");
    tick_rate_a: assert property (tick_r |-> $past(cnt_r) ==
        $past(last) && $past(any_sync)) else $error("sample tick off period");
    readback_a: assert property (rd_word[15:13] == IWC_REG_ADDR
        && rd_word[9:8] == IWC_RSVD_VAL) else $error("fixed bits wrong");
    write_cov: cover property (cs_rise && frame_ok && !reg_r.write_lock);
    locked_cov: cover property (cs_rise && frame_ok && reg_r.write_lock);
    wake_cov: cover property (O_WAKE_IN_A_IRQ && reg_r.wake_in_a_sync_sample);
    lowpwr_cov: cover property (O_XCVR_LOWPOWER && !normal);
endmodule

/* bench/iwc_spi_master.sv */
// Serial bus master model standing in for the microcontroller.
`timescale 1ns/100ps
module iwc_spi_master (
    input wire logic clk, // Core clock.
    input wire logic sdo, // Data from the device.
    input wire logic sdo_oe, // Device drives the data line.
    output logic sck, // Serial clock, still outside frames.
    output logic sdi, // Serial data to the device.
    output logic cs_n // Chip select, active low.
);
    // Idle levels at time zero.
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        cs_n = 1'b1;
    end
    // Waits a number of core clock edges.
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Sends n bits MSB first; read bits are unknown while not driven.
    task automatic xfer(input logic [15:0] tx, input int n,
                        output logic [15:0] rx);
        rx = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        wait_clk(8);
        for (int i = 0; i < n; i++) begin
            sdi <= tx[15 - i];
            wait_clk(6);
            rx = {rx[14:0], sdo_oe ? sdo : 1'bx};
            sck <= 1'b1;
            wait_clk(6);
            sck <= 1'b0;
        end
        wait_clk(6);
        cs_n <= 1'b1;
        // A released line must not keep showing the last bit.
        sdi <= ~sdi;
        wait_clk(9);
    endtask
endmodule

/* bench/iwc_ctrl_tb.sv */
// Self-checking testbench of the interrupt and wake control register.
`timescale 1ns/100ps
module iwc_ctrl_tb;
    import iwc_pkg::*;
    localparam int SHORT = 64;
    localparam int LONG = 256;
    logic clk, rst_n, sck, sdi, cs_n, sdo, sdo_oe, trip, bias;
    logic main_warn, can_warn, wake_a, wake_b, rate;
    logic main_irq, can_irq, wa_irq, wb_irq;
    logic [1:0] mode;
    logic [15:0] rx, wr, prev;
    iwc_xcvr_t xcvr;
    int errors, total_checks, seed, na, nb;

    iwc_ctrl #(.SHORT_CYC(SHORT), .LONG_CYC(LONG), .BIAS_CYC(4)) iwc_ctrl_inst (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SPI_SCK(sck), .I_SPI_SDI(sdi),
        .I_SPI_CS_N(cs_n), .O_SPI_SDO(sdo), .O_SPI_SDO_OE(sdo_oe),
        .I_CHIP_MODE_FIELD(mode), .I_MAIN_SUPPLY_UV_WARN(main_warn),
        .I_TRANSCEIVER_SUPPLY_UV_WARN(can_warn), .I_WAKE_IN_A(wake_a),
        .I_WAKE_IN_B(wake_b), .I_WAKE_BIAS_RATE_SEL(rate),
        .O_MAIN_SUPPLY_UV_IRQ(main_irq), .O_CAN_SUPPLY_UV_IRQ(can_irq),
        .O_WAKE_IN_A_IRQ(wa_irq), .O_WAKE_IN_B_IRQ(wb_irq),
        .O_WAKE_BIAS_OUT(bias), .O_XCVR_ACTIVE(xcvr.active),
        .O_XCVR_LOWPOWER(xcvr.lowpower), .O_BUS_WAKE_DET_EN(xcvr.bus_wake_det_en),
        .O_CAN_WAKE_IRQ_EN(xcvr.can_wake_irq_en),
        .O_TRANSCEIVER_RX_WAKE_CLR(xcvr.rx_wake_clr),
        .O_RESET_TRIP_LEVEL_SEL(trip));

    iwc_spi_master iwc_spi_master_inst (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe),
        .sck(sck), .sdi(sdi), .cs_n(cs_n));

    // Core clock of 25 ns period.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Read word expected after writing d.
    function automatic logic [15:0] exp_word(input logic [15:0] d);
        return {IWC_REG_ADDR, d[12:10], IWC_RSVD_VAL, d[7:0]};
    endfunction

    // Transceiver controls expected for a mode and low-power bit.
    function automatic logic [15:0] exp_xcvr(input logic [1:0] m, input logic lp);
        iwc_xcvr_t x;
        x = '0;
        if (lp) begin
            x.lowpower = 1'b1;
            x.bus_wake_det_en = 1'b1;
            x.can_wake_irq_en = 1'b1;
        end else if (m[IWC_MODE_NORMAL_BIT]) begin
            x.active = 1'b1;
            x.rx_wake_clr = 1'b1;
        end
        return {11'h0, x};
    endfunction

    // Word comparison.
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask

    // Single bit comparison.
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0, got}, {15'h0, exp});
    endtask

    // Writes a word, then reads it back with an ignored frame.
    task automatic wr_rd(input logic [15:0] d);
        iwc_spi_master_inst.xfer(d, 16, rx);
        iwc_spi_master_inst.xfer(16'h0000, 16, rx);
    endtask

    // Counts wake request pulses over twelve cycles; unknown counts large.
    task automatic count_irq(output int a, output int b);
        a = 0;
        b = 0;
        repeat (12) begin
            @(negedge clk);
            a += (wa_irq === 1'b1) ? 1 : ((wa_irq === 1'b0) ? 0 : 100);
            b += (wb_irq === 1'b1) ? 1 : ((wb_irq === 1'b0) ? 0 : 100);
        end
    endtask

    // Cycles until the next rising edge of the bias pulse, bounded.
    task automatic rise_wait(output int n);
        logic b0;
        n = 0;
        b0 = 1'b1;
        while (n < 3000) begin
            @(negedge clk);
            n++;
            if (bias === 1'b1 && b0 === 1'b0) break;
            b0 = bias;
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end

    // Main sequence.
    initial begin
        seed = 57828;
        errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        mode = 2'h0;
        main_warn = 1'b0;
        can_warn = 1'b0;
        wake_a = 1'b1;
        wake_b = 1'b1;
        rate = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        iwc_spi_master_inst.xfer(16'h1fff, 16, rx);
        chk_word(rx, 16'h4000);
        iwc_spi_master_inst.xfer(16'h0000, 16, rx);
        chk_word(rx, 16'h4000);
        chk_word({11'h0, xcvr}, exp_xcvr(mode, 1'b0));
        $display("test reset done");
        // Every mode with both low-power choices, random other fields.
        for (int k = 0; k < 8; k++) begin
            wr = 16'($random(seed));
            wr[15:12] = {IWC_REG_ADDR, 1'b0};
            wr[IWC_LOWPWR_POS] = k[2];
            @(posedge clk);
            mode <= k[1:0];
            wr_rd(wr);
            chk_word(rx, exp_word(wr));
            chk_bit(trip, wr[IWC_TRIP_POS]);
            chk_word({11'h0, xcvr}, exp_xcvr(mode, wr[3]));
        end
        prev = exp_word(wr);
        iwc_spi_master_inst.xfer(16'h5fff, 15, rx);
        iwc_spi_master_inst.xfer(16'h0000, 16, rx);
        chk_word(rx, prev);
        $display("test writes done");
        // Supply warnings with each pair of enables.
        for (int e = 0; e < 4; e++) begin
            iwc_spi_master_inst.xfer({IWC_REG_ADDR, 1'b0, 2'(e), 10'h0}, 16, rx);
            @(posedge clk);
            main_warn <= 1'b1;
            can_warn <= 1'b1;
            @(posedge clk);
            main_warn <= 1'b0;
            can_warn <= 1'b0;
            @(negedge clk);
            chk_bit(main_irq, e[1]);
            chk_bit(can_irq, e[0]);
        end
        $display("test supply done");
        // Each edge code on both wake inputs, continuous sampling.
        for (int c = 0; c < 4; c++) begin
            iwc_spi_master_inst.xfer({IWC_REG_ADDR, 5'h0, 2'(c), 2'(c), 4'h0},
                16, rx);
            chk_bit(bias, 1'b0);
            @(posedge clk);
            wake_a <= 1'b0;
            wake_b <= 1'b0;
            count_irq(na, nb);
            chk_word(16'(na), {15'h0, c[1]});
            chk_word(16'(nb), {15'h0, c[1]});
            @(posedge clk);
            wake_a <= 1'b1;
            wake_b <= 1'b1;
            count_irq(na, nb);
            chk_word(16'(na), {15'h0, c[0]});
            chk_word(16'(nb), {15'h0, c[0]});
        end
        $display("test wake done");
        // Synchronized sampling period for both bias rates.
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            rate <= r[0];
            iwc_spi_master_inst.xfer({IWC_REG_ADDR, 13'h0003}, 16, rx);
            rise_wait(na);
            rise_wait(na);
            chk_word(16'(na), r[0] ? 16'(LONG) : 16'(SHORT));
        end
        $display("test sync done");
        // Locked register ignores later writes.
        wr = {IWC_REG_ADDR, 13'h1a5a};
        iwc_spi_master_inst.xfer(wr, 16, rx);
        wr_rd({IWC_REG_ADDR, 13'h0fff});
        chk_word(rx, exp_word(wr));
        $display("test lock done");
        end_of_test();
    end
endmodule
